// *** rtl/tba_bus_if.sv ***
// two-wire bus carrier: open-drain sda resolved from both ends' enables, scl from the master's alone
interface tba_bus_if;
   logic scl_o_m;
   logic scl_oe_n_m;
   logic sda_o_m;
   logic sda_oe_n_m;
   logic sda_o_s;
   logic sda_oe_n_s;
   logic scl;
   logic sda;

   // wired-and: a line is low when any end drives (enable low) a zero
   assign scl = !(!scl_oe_n_m && !scl_o_m);
   assign sda = !((!sda_oe_n_m && !sda_o_m) || (!sda_oe_n_s && !sda_o_s));

   modport master (
      output scl_o_m, scl_oe_n_m, sda_o_m, sda_oe_n_m,
      input  scl, sda
   );
   modport slave (
      output sda_o_s, sda_oe_n_s,
      input  scl, sda
   );
endinterface : tba_bus_if

// *** rtl/tba_master.sv ***
// master end: issues start/restart/stop, bytes, samples acks and read data
module tba_master #(
   parameter int HALF = tba_pkg::HALF_BIT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset,
   tba_bus_if.master       bus,
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd_op,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_ack_out,
   output logic            cmd_ready,
   output logic            done,
   output logic [7:0]      rd_data,
   output logic            got_ack
);
   import tba_pkg::*;

   // op: 0 start/restart, 1 write byte, 2 read byte, 3 stop
   typedef enum logic [4:0] {
      MS_IDLE  = 5'b00001,
      MS_START = 5'b00010,
      MS_BIT   = 5'b00100,
      MS_STOP  = 5'b01000,
      MS_DONE  = 5'b10000
   } tba_mst_t;

   tba_mst_t   state;
   logic [1:0] op;
   logic [8:0] sh;
   logic [3:0] nbit;
   logic [1:0] phase;
   logic [7:0] tick;
   logic       tick_end;
   logic       scl_drv;
   logic       sda_drv;
   logic [8:0] rsh;

   assign tick_end  = tick == 8'(HALF - 1);
   assign cmd_ready = state == MS_IDLE;

   always_ff @(posedge clk) begin
      if (reset || state == MS_IDLE || tick_end) tick <= 8'h00;
      else tick <= tick + 8'h01;
   end

   // a write sends data then releases for ack; a read releases then drives ack
   always_ff @(posedge clk) begin
      if (reset) begin
         state   <= MS_IDLE;
         op      <= 2'h0;
         sh      <= 9'h1ff;
         nbit    <= BIT_CNT_ZERO;
         phase   <= 2'h0;
         scl_drv <= 1'b1;
         sda_drv <= 1'b1;
         done    <= 1'b0;
         rd_data <= DATA_ZERO;
         got_ack <= 1'b0;
         rsh     <= 9'h000;
      end else begin
         done <= 1'b0;
         case (state)
            MS_IDLE: if (cmd_valid) begin
               op    <= cmd_op;
               phase <= 2'h0;
               nbit  <= BIT_CNT_ZERO;
               sh    <= cmd_op == 2'h1 ? {cmd_data, 1'b1} : {8'hff, !cmd_ack_out};
               state <= cmd_op == 2'h0 ? MS_START : cmd_op == 2'h3 ? MS_STOP : MS_BIT;
            end
            MS_START: if (tick_end) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_drv <= 1'b1;
                  2'h1: scl_drv <= 1'b1;
                  2'h2: sda_drv <= 1'b0;
                  default: begin
                     scl_drv <= 1'b0;
                     state   <= MS_DONE;
                  end
               endcase
            end
            MS_BIT: if (tick_end) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_drv <= sh[8];
                  2'h1: scl_drv <= 1'b1;
                  2'h2: rsh <= {rsh[7:0], bus.sda};
                  default: begin
                     scl_drv <= 1'b0;
                     sh      <= {sh[7:0], 1'b1};
                     nbit    <= nbit + 4'h1;
                     if (nbit == ACK_SLOT) begin
                        state   <= MS_DONE;
                        rd_data <= rsh[8:1];
                        got_ack <= !rsh[0];
                     end
                  end
               endcase
            end
            MS_STOP: if (tick_end) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: sda_drv <= 1'b0;
                  2'h1: scl_drv <= 1'b1;
                  2'h2: sda_drv <= 1'b1;
                  default: state <= MS_DONE;
               endcase
            end
            MS_DONE: begin
               done  <= 1'b1;
               state <= MS_IDLE;
            end
            default: state <= MS_IDLE;
         endcase
      end
   end

   // on read, data slots released so the slave can drive
   logic sda_out;
   assign sda_out = (state == MS_BIT && op == 2'h2 && nbit != ACK_SLOT) ? 1'b1 : sda_drv;
   assign bus.scl_o_m    = 1'b0;
   assign bus.scl_oe_n_m = scl_drv;
   assign bus.sda_o_m    = 1'b0;
   assign bus.sda_oe_n_m = sda_out;
endmodule : tba_master

// *** rtl/tba_pkg.sv ***
// shared constants for the 10-bit address match pair
package tba_pkg;
   localparam logic [4:0] TEN_BIT_PREFIX   = 5'h1e;   // 11110
   localparam logic [4:0] RESERVED_PREFIX  = 5'h1f;   // 11111
   localparam logic [7:0] GENERAL_CALL     = 8'h00;
   localparam logic [7:0] START_BYTE       = 8'h01;
   localparam int         BITS_PER_BYTE    = 8;
   localparam logic [3:0] ACK_SLOT         = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO     = 4'h0;
   localparam logic [9:0] DEFAULT_ADDR10   = 10'h2a5;
   localparam logic [6:0] DEFAULT_ADDR7    = 7'h3a;
   localparam logic [7:0] DATA_ZERO        = 8'h00;
   localparam int         HALF_BIT_CYCLES  = 16;
endpackage : tba_pkg

// *** rtl/tba_slave.sv ***
// slave end: start/stop detection, 7/10-bit address match, byte transfer
// Function
// - 11110XX first byte starts 10-bit address
// - 11111XX first bytes are never 10-bit
// - address built from two bytes after start
// - XX are high bits, bit0 is direction
// - write: second byte holds low eight bits
// - read first byte: next byte is slave data
// - prefix plus write matches, ack first byte
// - second byte full match gives second ack
// - selected until stop or other address
// - remembered selection acks read re-address
// - transmitter stays selected until stop/other address
// - unselected slaves ignore 10-bit read prefix
// - 7-bit or 10-bit address decoded, chosen by ten_bit_mode
// - speed mode independent, pure bit-level logic
// - master reverses only after repeated start
// - master may address another slave after restart
// - every byte followed by one ack slot
// - start resets bus logic to address phase
// - general call acknowledged like 7-bit slave
// - start byte tolerated, never acknowledged
module tba_slave #(
   parameter logic [9:0] OWN_ADDR10 = tba_pkg::DEFAULT_ADDR10,
   parameter logic [6:0] OWN_ADDR7  = tba_pkg::DEFAULT_ADDR7
) (
   input  wire logic       clk,
   input  wire logic       reset,
   tba_bus_if.slave        bus,
   input  wire logic       ten_bit_mode,
   input  wire logic       gc_enable,
   input  wire logic [7:0] tx_data,
   output logic            tx_load,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            selected,
   output logic            transmitting,
   output logic            general_call
);
   import tba_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_ADDR1 = 6'b000010,
      ST_ADDR2 = 6'b000100,
      ST_RX    = 6'b001000,
      ST_TX    = 6'b010000,
      ST_IGN   = 6'b100000
   } tba_sst_t;

   // =====================================================================
   // input synchronisers (three stages, second and third must agree)
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic       scl_f;
   logic       sda_f;
   logic       scl_prev;
   logic       sda_prev;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end else begin
         scl_sync <= {scl_sync[1:0], bus.scl};
         sda_sync <= {sda_sync[1:0], bus.sda};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end else begin
         if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise   = scl_f && !scl_prev;
   assign scl_fall   = !scl_f && scl_prev;
   assign start_cond = scl_f && scl_prev && sda_prev && !sda_f;
   assign stop_cond  = scl_f && scl_prev && !sda_prev && sda_f;

   // =====================================================================
   // bit and byte counting
   tba_sst_t   state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic       ack_pend;
   logic       in_ack;
   logic       byte_done;
   logic [7:0] next_byte;
   logic       slot;
   logic       slot_end;

   assign in_ack    = (bit_cnt == ACK_SLOT);
   assign next_byte = {shreg[6:0], sda_f};
   assign byte_done = scl_rise && (bit_cnt == ACK_SLOT - 4'h1);
   assign slot_end  = scl_fall && in_ack && slot;   // end of the ack bit, not of bit 8

   always_ff @(posedge clk) begin
      if (reset || start_cond) begin
         bit_cnt <= BIT_CNT_ZERO;
         slot    <= 1'b0;
      end else if (slot_end) begin
         bit_cnt <= BIT_CNT_ZERO;
         slot    <= 1'b0;
      end else if (scl_fall && in_ack) begin
         slot <= 1'b1;
      end else if (scl_rise && !in_ack) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) shreg <= DATA_ZERO;
      else if (scl_rise && !in_ack) shreg <= next_byte;
   end

   // first byte decode
   function automatic logic is_ten_prefix(input logic [7:0] b);
      return b[7:3] == TEN_BIT_PREFIX;
   endfunction : is_ten_prefix

   // =====================================================================
   // addressing state, remembered selection
   logic       remembered;
   logic       first_read;
   logic       ack_drive;
   logic       master_ack;
   logic       tx_bit;
   logic [7:0] txsh;

   always_ff @(posedge clk) begin
      if (reset) begin
         state        <= ST_IDLE;
         ack_pend     <= 1'b0;
         remembered   <= 1'b0;
         general_call <= 1'b0;
         first_read   <= 1'b0;
      end else if (stop_cond) begin
         state        <= ST_IDLE;
         ack_pend     <= 1'b0;
         remembered   <= 1'b0;
         general_call <= 1'b0;
      end else if (start_cond) begin
         state        <= ST_ADDR1;
         ack_pend     <= 1'b0;
         general_call <= 1'b0;
      end else if (byte_done) begin
         ack_pend <= 1'b0;
         case (state)
            ST_ADDR1: begin
               first_read <= next_byte[0];
               if (ten_bit_mode && is_ten_prefix(next_byte)
                   && next_byte[2:1] == OWN_ADDR10[9:8]) begin
                  if (!next_byte[0]) begin
                     state    <= ST_ADDR2;
                     ack_pend <= 1'b1;
                  end else if (remembered) begin
                     state    <= ST_TX;
                     ack_pend <= 1'b1;
                  end else begin
                     state <= ST_IGN;
                  end
               end else if (!ten_bit_mode && next_byte[7:1] == OWN_ADDR7) begin
                  state      <= next_byte[0] ? ST_TX : ST_RX;
                  ack_pend   <= 1'b1;
                  remembered <= 1'b0;
               end else if (gc_enable && next_byte == GENERAL_CALL) begin
                  state        <= ST_RX;
                  ack_pend     <= 1'b1;
                  general_call <= 1'b1;
               end else begin
                  // start byte and other addresses fall here unacknowledged
                  state      <= ST_IGN;
                  remembered <= 1'b0;
               end
            end
            ST_ADDR2: begin
               if (next_byte == OWN_ADDR10[7:0]) begin
                  state      <= ST_RX;
                  ack_pend   <= 1'b1;
                  remembered <= 1'b1;
               end else begin
                  state      <= ST_IGN;
                  remembered <= 1'b0;
               end
            end
            ST_RX: ack_pend <= 1'b1;
            default: ;
         endcase
      end else if (slot_end) begin
         ack_pend <= 1'b0;
      end
   end

   // hold sampled master ack during transmit
   always_ff @(posedge clk) begin
      if (reset) master_ack <= 1'b0;
      else if (scl_rise && in_ack) master_ack <= !sda_f;
   end

   // =====================================================================
   // data path toward the user and toward the master
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_data  <= DATA_ZERO;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= byte_done && state == ST_RX;
         if (byte_done && state == ST_RX) rx_data <= next_byte;
      end
   end

   logic tx_start;
   logic tx_next;
   assign tx_start = slot_end && ack_pend && state == ST_TX;
   assign tx_next  = slot_end && state == ST_TX && master_ack && !ack_pend;
   assign tx_load  = tx_start || tx_next;

   always_ff @(posedge clk) begin
      if (reset) txsh <= DATA_ZERO;
      else if (tx_load) txsh <= tx_data;
      else if (scl_fall && state == ST_TX && !in_ack && bit_cnt != BIT_CNT_ZERO)
         txsh <= {txsh[6:0], 1'b1};
   end

   // a master nack ends our drive; we release until the next start
   logic tx_active;
   always_ff @(posedge clk) begin
      if (reset || start_cond || stop_cond) tx_active <= 1'b0;
      else if (tx_load) tx_active <= 1'b1;
      else if (slot_end && state == ST_TX) tx_active <= 1'b0;
   end

   assign ack_drive = ack_pend && in_ack && slot;
   assign tx_bit    = tx_active && !slot && !txsh[7];

   // drive low only, via enable; otherwise released
   always_ff @(posedge clk) begin
      if (reset) begin
         bus.sda_o_s    <= 1'b0;
         bus.sda_oe_n_s <= 1'b1;
      end else begin
         bus.sda_o_s    <= 1'b0;
         bus.sda_oe_n_s <= !(ack_drive || tx_bit);
      end
   end

   assign selected     = state == ST_RX || state == ST_TX;
   assign transmitting = state == ST_TX;
endmodule : tba_slave

// *** tb/tba_bus_chk.sv ***
// concurrent checks on the shared two-wire bus and the slave's status outputs
// ==========================================
// ports
module tba_bus_chk #(
   parameter int HALF = tba_pkg::HALF_BIT_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_oe_n_s,
   input wire logic selected,
   input wire logic transmitting,
   input wire logic rx_valid,
   input wire logic tx_load,
   input wire logic general_call,
   input wire logic gc_enable
);
   // slave sees the lines ~3 clocks late, so the ack may overrun one bit slot a little
   localparam logic [7:0] ACK_MAX = 8'(4 * HALF + 8);
   logic [7:0] hi_cnt;
   logic [7:0] drv_cnt;

   // ==========================================
   // helper counters
   always_ff @(posedge clk) begin
      if (reset || !scl) begin
         hi_cnt <= 8'h00;
      end else if (hi_cnt != 8'hff) begin
         hi_cnt <= hi_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || sda_oe_n_s || transmitting) begin
         drv_cnt <= 8'h00;
      end else if (drv_cnt != 8'hff) begin
         drv_cnt <= drv_cnt + 8'h01;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ==========================================
   // assertions
   chk_hold_high: assert property (hi_cnt > 8'h04 |-> $stable(sda_oe_n_s))
      else $error("slave moved sda while scl high");
   chk_ack_length: assert property (!transmitting |-> drv_cnt <= ACK_MAX)
      else $error("slave held ack past one slot");
   chk_start_reset: assert property (scl && $past(scl) && $fell(sda) |-> ##[0:8] (!transmitting && sda_oe_n_s))
      else $error("start did not return slave to address phase");
   chk_stop_release: assert property (scl && $past(scl) && $rose(sda) |-> ##[0:8] !selected)
      else $error("slave still selected after stop");
   chk_tx_sel: assert property (transmitting |-> selected)
      else $error("transmitting while not selected");
   chk_rx_not_tx: assert property (rx_valid |-> !transmitting)
      else $error("byte received while transmitting");
   chk_load_tx: assert property (tx_load |-> ##[0:2] transmitting)
      else $error("transmit byte loaded outside transmit phase");
   chk_gc_enable: assert property ($rose(general_call) |-> gc_enable)
      else $error("general call taken while disabled");
endmodule : tba_bus_chk

// *** tb/ten_bit_slave_address_match_tb.sv ***
// self-checking bench: master and slave joined over the bus carrier
module ten_bit_slave_address_match_tb import tba_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         HALF = 8;
   localparam logic [9:0] A10  = DEFAULT_ADDR10;
   logic        clk = 1'b0;
   logic        reset;
   logic        cmd_valid;
   logic [1:0]  cmd_op;
   logic [7:0]  cmd_data;
   logic        cmd_ack_out;
   logic        cmd_ready;
   logic        done;
   logic [7:0]  rd_data;
   logic        got_ack;
   logic        ten_bit_mode;
   logic        gc_enable;
   logic [7:0]  tx_data;
   logic        tx_load;
   logic [7:0]  rx_data;
   logic        rx_valid;
   logic        selected;
   logic        transmitting;
   logic        general_call;
   logic [7:0]  d;
   logic [31:0] seed = 32'h4c0a;
   int          failures = 0;
   int          cmp_count = 0;
   int          rx_count = 0;
   int          tx_count = 0;

   always #4 clk = ~clk;

   // one-cycle pulses, counted where they stand
   always @(negedge clk) begin
      if (rx_valid === 1'b1) rx_count++;
      if (tx_load === 1'b1) tx_count++;
   end

   tba_bus_if bus ();
   tba_master #(.HALF(HALF)) tba_master_inst (.clk(clk), .reset(reset), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack_out(cmd_ack_out),
      .cmd_ready(cmd_ready), .done(done), .rd_data(rd_data), .got_ack(got_ack));
   tba_slave #(.OWN_ADDR10(A10), .OWN_ADDR7(DEFAULT_ADDR7)) tba_slave_inst (.clk(clk),
      .reset(reset), .bus(bus), .ten_bit_mode(ten_bit_mode), .gc_enable(gc_enable),
      .tx_data(tx_data), .tx_load(tx_load), .rx_data(rx_data), .rx_valid(rx_valid),
      .selected(selected), .transmitting(transmitting), .general_call(general_call));
   tba_bus_chk #(.HALF(HALF)) tba_bus_chk_inst (.clk(clk), .reset(reset), .scl(bus.scl),
      .sda(bus.sda), .sda_oe_n_s(bus.sda_oe_n_s), .selected(selected),
      .transmitting(transmitting), .rx_valid(rx_valid), .tx_load(tx_load),
      .general_call(general_call), .gc_enable(gc_enable));

   // ==========================================
   // helpers
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   function automatic logic [7:0] hb(input logic [9:0] a, input logic rd);
      return {TEN_BIT_PREFIX, a[9:8], rd};
   endfunction : hb

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // entered at a falling edge; every wait is bounded
   task automatic cmd(input logic [1:0] o, input logic [7:0] v, input logic ao);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) n = 1000;
      cmd_op = o;
      cmd_data = v;
      cmd_ack_out = ao;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 1000) begin
         failures++;
         $display("CHECK FAILED at %0t: command timed out", $time);
         end_sim();
      end
   endtask : cmd

   task automatic sr();
      cmd(2'h0, 8'h00, 1'b0);
   endtask : sr

   task automatic sp();
      cmd(2'h3, 8'h00, 1'b0);
   endtask : sp

   task automatic wa(input logic [7:0] v, input logic a, input string w);
      cmd(2'h1, v, 1'b0);
      check({7'h0, got_ack}, {7'h0, a}, w);
   endtask : wa

   task automatic rb(input logic ao, input string w);
      cmd(2'h2, 8'h00, ao);
      check(rd_data, tx_data, w);
   endtask : rb

   // ==========================================
   // main sequence
   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_data = 8'h00;
      cmd_ack_out = 1'b0;
      ten_bit_mode = 1'b1;
      gc_enable = 1'b1;
      tx_data = 8'h00;
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      sr();
      wa(hb(A10, 1'b0), 1'b1, "first byte");
      wa(A10[7:0], 1'b1, "second byte");
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
         wa(d, 1'b1, "data ack");
         check(rx_data, d, "rx data");
      end
      check({7'h0, selected}, 8'h01, "selected");
      tx_data = rnd();
      sr();
      wa(hb(A10, 1'b1), 1'b1, "read re-address");
      check({7'h0, transmitting}, 8'h01, "transmitting");
      rb(1'b1, "read one");
      tx_data = rnd();
      rb(1'b0, "read last");
      sp();
      check({7'h0, selected}, 8'h00, "stop deselect");
      sr();
      wa(hb(A10, 1'b1), 1'b0, "unselected read");
      for (int i = 0; i < 4; i++) begin
         sr();
         wa({RESERVED_PREFIX, 2'(i), 1'b0}, 1'b0, "reserved prefix");
      end
      // a wrong low byte must leave the rest of the transfer unanswered
      sr();
      wa(hb(A10, 1'b0), 1'b1, "first byte");
      wa(A10[7:0] ^ (rnd() | 8'h01), 1'b0, "wrong low byte");
      wa(rnd(), 1'b0, "ignored data");
      sr();
      wa(hb(A10, 1'b0), 1'b1, "first after restart");
      wa(A10[7:0], 1'b1, "second after restart");
      sr();
      wa({TEN_BIT_PREFIX, ~A10[9:8], 1'b0}, 1'b0, "other slave");
      check({7'h0, selected}, 8'h00, "other slave deselect");
      sr();
      wa(START_BYTE, 1'b0, "start byte");
      sr();
      wa(hb(A10, 1'b0), 1'b1, "first after start byte");
      wa(A10[7:0], 1'b1, "second after start byte");
      sr();
      wa(GENERAL_CALL, 1'b1, "general call");
      check({7'h0, general_call}, 8'h01, "general call flag");
      sp();
      gc_enable = 1'b0;
      sr();
      wa(GENERAL_CALL, 1'b0, "general call off");
      sp();
      gc_enable = 1'b1;
      // 7-bit then 10-bit address inside one transfer
      ten_bit_mode = 1'b0;
      sr();
      wa({DEFAULT_ADDR7, 1'b0}, 1'b1, "seven bit");
      sr();
      wa(hb(A10, 1'b0), 1'b0, "ten bit to seven bit");
      sp();
      check(8'(rx_count), 8'h04, "received bytes");
      check(8'(tx_count), 8'h02, "transmit loads");
      end_sim();
   end
endmodule : ten_bit_slave_address_match_tb
